// File: t1ra_top.sv
// T1 receive alarm detection and polled status registers
`timescale 1ns/1ps
module t1ra_top #(
	parameter int BLUE_WINDOW = t1ra_pkg::BLUE_WINDOW_CYC,
	parameter int JA_DEPTH = 32,
	parameter int JA_W = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic rx_clock_in,
	input wire logic rx_positive_in,
	input wire logic rx_negative_in,
	input wire logic rx_level_hi,
	input wire logic rx_level_lo,
	input wire logic line_bit_valid,
	input wire logic line_bit,
	input wire logic [JA_W-1:0] jitter_fill,
	input wire logic rx_sync_loss_flag,
	input wire logic esf_mode,
	input wire logic yellow_mode_select,
	input wire logic chan_valid,
	input wire logic chan_bit2,
	input wire logic fbit12_valid,
	input wire logic fbit12,
	input wire logic fdl_word_valid,
	input wire logic [15:0] fdl_word,
	input wire logic rx_mf_pulse,
	input wire logic tx_mf_pulse,
	input wire logic [7:0] host_addr,
	input wire logic [7:0] host_wdata,
	input wire logic host_wr,
	input wire logic host_rd,
	output logic [7:0] host_rdata,
	output logic int_n
);
	localparam int NSYNC = 5;
	localparam int BW = $clog2(BLUE_WINDOW + 1);

	// Pin synchronisers: clock, pos, neg, level hi, level lo
	logic [NSYNC-1:0] pin_raw, sync1, sync2;
	logic rclk_prev;
	assign pin_raw = {rx_clock_in, rx_positive_in, rx_negative_in,
		rx_level_hi, rx_level_lo};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
				end else begin
					sync1[gi] <= pin_raw[gi];
					sync2[gi] <= sync1[gi];
				end
			end
		end
	endgenerate

	logic rclk_s, rclk_rise, rclk_edge, rx_bit;
	assign rclk_s = sync2[4];
	assign rclk_rise = rclk_s & ~rclk_prev;
	assign rclk_edge = rclk_s ^ rclk_prev;
	assign rx_bit = sync2[3] | sync2[2];

	// Receive clock loss and jitter limit
	logic [15:0] idle_cnt, next_idle_cnt;
	logic clk_loss, next_clk_loss, jitter_limit_flag;
	assign jitter_limit_flag = jitter_fill >= JA_W'(JA_DEPTH - t1ra_pkg::JITTER_MARGIN);
	always_comb begin
		next_idle_cnt = idle_cnt;
		next_clk_loss = clk_loss;
		if (rclk_edge) begin
			next_idle_cnt = 16'h0000;
			next_clk_loss = 1'b0;
		end else if (idle_cnt != 16'(t1ra_pkg::CLK_LOSS_CYC)) begin
			next_idle_cnt = idle_cnt + 16'h0001;
		end else begin
			next_clk_loss = 1'b1;
		end
	end

	// Blue alarm: zero count over a fixed window of time
	logic [BW-1:0] blue_cnt, next_blue_cnt;
	logic [2:0] blue_zeros, next_blue_zeros;
	logic blue, next_blue;
	always_comb begin
		next_blue_cnt = blue_cnt + BW'(1);
		next_blue_zeros = blue_zeros;
		next_blue = blue;
		if (rclk_rise && !rx_bit && blue_zeros <= 3'(t1ra_pkg::BLUE_ZERO_MAX))
			next_blue_zeros = blue_zeros + 3'h1;
		if (blue_cnt == BW'(BLUE_WINDOW - 1)) begin
			// Framing zeros keep a framed all-ones signal above the limit
			next_blue = next_blue_zeros <= 3'(t1ra_pkg::BLUE_ZERO_MAX);
			next_blue_cnt = '0;
			next_blue_zeros = 3'h0;
		end
	end

	// Yellow alarm detectors, one per mode
	logic [7:0] ch_cnt, next_ch_cnt;
	logic [8:0] ch_zeros, next_ch_zeros;
	logic y_d4, next_y_d4, f12_prev, next_f12_prev, y_f12, next_y_f12;
	logic [4:0] esf_run, next_esf_run, esf_hits, next_esf_hits;
	logic [3:0] esf_win, next_esf_win;
	logic y_esf, next_y_esf, esf_hit, yellow;
	assign esf_hit = fdl_word == t1ra_pkg::ESF_YELLOW_WORD;
	always_comb begin
		next_ch_cnt = ch_cnt;
		next_ch_zeros = ch_zeros;
		next_y_d4 = y_d4;
		if (chan_valid) begin
			next_ch_cnt = ch_cnt + 8'h01;
			next_ch_zeros = ch_zeros + {8'h00, ~chan_bit2};
			if (ch_cnt == 8'(t1ra_pkg::D4_CHANNELS - 1)) begin
				next_y_d4 = next_ch_zeros >= 9'(t1ra_pkg::D4_ZERO_SET);
				next_ch_zeros = 9'h000;
			end
		end
		next_f12_prev = f12_prev;
		next_y_f12 = y_f12;
		if (fbit12_valid) begin
			next_f12_prev = fbit12;
			if (fbit12 == f12_prev)
				next_y_f12 = fbit12;
		end
		next_esf_run = esf_run;
		next_esf_hits = esf_hits;
		next_esf_win = esf_win;
		next_y_esf = y_esf;
		if (fdl_word_valid) begin
			next_esf_win = esf_win + 4'h1;
			next_esf_hits = esf_hits + {4'h0, esf_hit};
			if (!esf_hit)
				next_esf_run = 5'h00;
			else if (esf_run != 5'(t1ra_pkg::ESF_RUN))
				next_esf_run = esf_run + 5'h01;
			if (next_esf_run == 5'(t1ra_pkg::ESF_RUN))
				next_y_esf = 1'b1;
			if (esf_win == 4'(t1ra_pkg::ESF_RUN - 1)) begin
				if (next_esf_hits <= 5'(t1ra_pkg::ESF_CLEAR_MAX))
					next_y_esf = 1'b0;
				next_esf_hits = 5'h00;
			end
		end
	end
	assign yellow = esf_mode ? y_esf : (yellow_mode_select ? y_f12 : y_d4);

	// Carrier loss on framer pins and on line data
	logic framer_carrier_loss_flag, line_carrier_loss_flag;
	t1ra_carrier_mon u_framer_mon (
		.clk(clk),
		.rstn(rstn),
		.bit_valid(rclk_rise),
		.bit_one(rx_bit),
		.loss(framer_carrier_loss_flag)
	);
	t1ra_carrier_mon u_line_mon (
		.clk(clk),
		.rstn(rstn),
		.bit_valid(line_bit_valid),
		.bit_one(line_bit),
		.loss(line_carrier_loss_flag)
	);

	// Host status registers
	logic [7:0] ri_live, as_live, es_live;
	logic [7:0] ri_q, as_q, es_q, next_ri_q, next_as_q, next_es_q;
	logic [1:0] mf_sticky, next_mf_sticky, mf_pend, next_mf_pend;
	logic [3:0] alarm_prev, alarm_now, al_pend, next_al_pend;
	logic [7:0] next_rdata;
	logic wr_ri, wr_as, wr_es, rd_as, rd_es;
	assign wr_ri = host_wr && host_addr == t1ra_pkg::ADDR_RX_INFO;
	assign wr_as = host_wr && host_addr == t1ra_pkg::ADDR_ALARM;
	assign wr_es = host_wr && host_addr == t1ra_pkg::ADDR_EVENT;
	assign rd_as = host_rd && host_addr == t1ra_pkg::ADDR_ALARM;
	assign rd_es = host_rd && host_addr == t1ra_pkg::ADDR_EVENT;
	assign alarm_now = {blue, yellow, line_carrier_loss_flag, rx_sync_loss_flag};

	always_comb begin
		ri_live = t1ra_pkg::REG_RESET;
		ri_live[t1ra_pkg::RI_LEVEL_LO +: 2] = {sync2[1], sync2[0]};
		ri_live[t1ra_pkg::RI_JITTER] = jitter_limit_flag;
		ri_live[t1ra_pkg::RI_CLK_LOSS] = clk_loss;
		ri_live[t1ra_pkg::RI_FRAMER_LOSS] = framer_carrier_loss_flag;
		as_live = t1ra_pkg::REG_RESET;
		as_live[t1ra_pkg::AS_SYNC_LOSS +: 4] = alarm_now;
		es_live = t1ra_pkg::REG_RESET;
		es_live[t1ra_pkg::ES_TX_MF +: 2] = mf_sticky;
		next_ri_q = wr_ri ? (ri_q & ~host_wdata) | (ri_live & host_wdata)
			: ri_q;
		next_as_q = wr_as ? (as_q & ~host_wdata) | (as_live & host_wdata)
			: as_q;
		next_es_q = wr_es ? (es_q & ~host_wdata) | (es_live & host_wdata)
			: es_q;
		// A mask write hands the events over; a new event still wins
		next_mf_sticky = mf_sticky;
		if (wr_es)
			next_mf_sticky = mf_sticky & ~host_wdata[t1ra_pkg::ES_TX_MF +: 2];
		next_mf_sticky = next_mf_sticky | {rx_mf_pulse, tx_mf_pulse};
		next_al_pend = rd_as ? 4'h0 : al_pend;
		next_al_pend = next_al_pend | (alarm_now ^ alarm_prev);
		next_mf_pend = rd_es ? 2'h0 : mf_pend;
		next_mf_pend = next_mf_pend | {rx_mf_pulse, tx_mf_pulse};
		case (host_addr)
			t1ra_pkg::ADDR_RX_INFO: next_rdata = ri_q;
			t1ra_pkg::ADDR_ALARM: next_rdata = as_q;
			t1ra_pkg::ADDR_EVENT: next_rdata = es_q;
			default: next_rdata = t1ra_pkg::REG_RESET;
		endcase
		if (!host_rd)
			next_rdata = host_rdata;
	end
	// Blue is only trustworthy when sync loss is also set
	assign int_n = ~(|al_pend | |mf_pend);

	// Receive clock edge and idle counter state
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rclk_prev <= 1'b0;
			idle_cnt <= 16'h0000;
			clk_loss <= 1'b0;
		end else begin
			rclk_prev <= rclk_s;
			idle_cnt <= next_idle_cnt;
			clk_loss <= next_clk_loss;
		end
	end

	// Blue window state
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			blue_cnt <= '0;
			blue_zeros <= 3'h0;
			blue <= 1'b0;
		end else begin
			blue_cnt <= next_blue_cnt;
			blue_zeros <= next_blue_zeros;
			blue <= next_blue;
		end
	end

	// Yellow detector state
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ch_cnt <= 8'h00;
			ch_zeros <= 9'h000;
			y_d4 <= 1'b0;
			f12_prev <= 1'b0;
			y_f12 <= 1'b0;
			esf_run <= 5'h00;
			esf_hits <= 5'h00;
			esf_win <= 4'h0;
			y_esf <= 1'b0;
		end else begin
			ch_cnt <= next_ch_cnt;
			ch_zeros <= next_ch_zeros;
			y_d4 <= next_y_d4;
			f12_prev <= next_f12_prev;
			y_f12 <= next_y_f12;
			esf_run <= next_esf_run;
			esf_hits <= next_esf_hits;
			esf_win <= next_esf_win;
			y_esf <= next_y_esf;
		end
	end

	// Host snapshots, sticky events and pending interrupts
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ri_q <= t1ra_pkg::REG_RESET;
			as_q <= t1ra_pkg::REG_RESET;
			es_q <= t1ra_pkg::REG_RESET;
			mf_sticky <= 2'h0;
			mf_pend <= 2'h0;
			al_pend <= 4'h0;
			alarm_prev <= 4'h0;
			host_rdata <= t1ra_pkg::REG_RESET;
		end else begin
			ri_q <= next_ri_q;
			as_q <= next_as_q;
			es_q <= next_es_q;
			mf_sticky <= next_mf_sticky;
			mf_pend <= next_mf_pend;
			al_pend <= next_al_pend;
			alarm_prev <= alarm_now;
			host_rdata <= next_rdata;
		end
	end
endmodule

// File: t1ra_pkg.sv
// Constants for the T1 receive alarm and status block
//
// Contract
// - Jitter-limit flag sets when buffer fill is within 4 bits of its limit.
// - Receive-clock-loss flag sets after 2 to 4 us without clock transition.
// - Framer carrier loss: 192 zeros set; 14 ones in 112 bits clear.
// - Receive level reports a two-bit code for four level bands.
// - Low three receive information bits are unassigned; host ignores them.
// - Blue sets on five or fewer zeros in 3 ms; six or more clear.
// - Blue survives 1e-3 errors and ignores framed all ones.
// - Bit-2 yellow: 254 of 256 channel bit 2 zero sets; fewer clears.
// - Twelfth F-bit yellow: two ones in a row set, two zeros clear.
// - ESF yellow: 16 consecutive 00FF sets; 14 or fewer of 16 clears.
// - Line carrier loss: 192 zeros set; 14 ones in 112 from first one clear.
// - Mask write refreshes only ones positions; zero positions hold value.
// - Any alarm change, either direction, pulls the interrupt low.
// - A multiframe event pulls the interrupt low.
// - Reading the causing register releases the interrupt if nothing pends.
package t1ra_pkg;
	localparam logic [7:0] ADDR_RX_INFO = 8'h10;
	localparam logic [7:0] ADDR_ALARM = 8'h20;
	localparam logic [7:0] ADDR_EVENT = 8'h21;
	// Receive information register fields
	localparam int RI_LEVEL_LO = 6;
	localparam int RI_JITTER = 5;
	localparam int RI_CLK_LOSS = 4;
	localparam int RI_FRAMER_LOSS = 3;
	// Alarm status register fields
	localparam int AS_BLUE = 3;
	localparam int AS_YELLOW = 2;
	localparam int AS_LINE_LOSS = 1;
	localparam int AS_SYNC_LOSS = 0;
	// Event status register fields
	localparam int ES_RX_MF = 7;
	localparam int ES_TX_MF = 6;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Timing
	localparam int CLK_MHZ = 200;
	localparam int CLK_LOSS_NS = 2000;
	localparam int CLK_LOSS_CYC = (CLK_LOSS_NS * CLK_MHZ + 999) / 1000;
	localparam int BLUE_WINDOW_US = 3000;
	localparam int BLUE_WINDOW_CYC = BLUE_WINDOW_US * CLK_MHZ;
	localparam int BLUE_ZERO_MAX = 5;
	// Alarm thresholds
	localparam int JITTER_MARGIN = 4;
	localparam int CARRIER_ZERO_RUN = 192;
	localparam int CARRIER_WINDOW = 112;
	localparam int CARRIER_ONES = 14;
	localparam int D4_CHANNELS = 256;
	localparam int D4_ZERO_SET = 254;
	localparam int ESF_RUN = 16;
	localparam int ESF_CLEAR_MAX = 14;
	localparam logic [15:0] ESF_YELLOW_WORD = 16'h00ff;
endpackage

// File: t1ra_carrier_mon.sv
// Carrier loss monitor: zero-run set, ones-in-window clear
`timescale 1ns/1ps
module t1ra_carrier_mon #(
	parameter int ZERO_RUN = t1ra_pkg::CARRIER_ZERO_RUN,
	parameter int WINDOW = t1ra_pkg::CARRIER_WINDOW,
	parameter int ONES = t1ra_pkg::CARRIER_ONES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic bit_valid,
	input wire logic bit_one,
	output logic loss
);
	logic [7:0] zero_cnt, next_zero_cnt;
	logic [7:0] win_cnt, next_win_cnt;
	logic [7:0] ones_cnt, next_ones_cnt;
	logic active, next_active, next_loss;

	always_comb begin
		next_zero_cnt = zero_cnt;
		next_win_cnt = win_cnt;
		next_ones_cnt = ones_cnt;
		next_active = active;
		next_loss = loss;
		if (bit_valid) begin
			if (bit_one)
				next_zero_cnt = 8'h00;
			else if (zero_cnt != 8'(ZERO_RUN))
				next_zero_cnt = zero_cnt + 8'h01;
			if (!loss) begin
				if (!bit_one && zero_cnt == 8'(ZERO_RUN - 1)) begin
					next_loss = 1'b1;
					next_active = 1'b0;
				end
			end else if (!active) begin
				// Clear window opens at the first one received
				if (bit_one) begin
					next_active = 1'b1;
					next_win_cnt = 8'h01;
					next_ones_cnt = 8'h01;
				end
			end else begin
				next_win_cnt = win_cnt + 8'h01;
				next_ones_cnt = ones_cnt + {7'h00, bit_one};
				if (next_ones_cnt >= 8'(ONES)) begin
					next_loss = 1'b0;
					next_active = 1'b0;
				end else if (win_cnt == 8'(WINDOW - 1)) begin
					next_active = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			zero_cnt <= 8'h00;
			win_cnt <= 8'h00;
			ones_cnt <= 8'h00;
			active <= 1'b0;
			loss <= 1'b0;
		end else begin
			zero_cnt <= next_zero_cnt;
			win_cnt <= next_win_cnt;
			ones_cnt <= next_ones_cnt;
			active <= next_active;
			loss <= next_loss;
		end
	end
endmodule

// File: t1ra_line_model.sv
// Line side model: receive clock and bipolar data
`timescale 1ns/1ps
module t1ra_line_model (
	input wire logic hold_clk,
	input wire logic zeros,
	output logic rx_clock_in,
	output logic rx_positive_in,
	output logic rx_negative_in
);
	logic mark;
	initial begin
		rx_clock_in = 1'b0;
		rx_positive_in = 1'b0;
		rx_negative_in = 1'b0;
		mark = 1'b0;
	end
	// Clock stands low while held
	always #40 begin
		rx_clock_in = hold_clk ? 1'b0 : ~rx_clock_in;
	end
	// Ones alternate polarity
	always @(negedge rx_clock_in) begin
		mark = ~mark;
		rx_positive_in = !zeros && mark;
		rx_negative_in = !zeros && !mark;
	end
endmodule

// File: t1ra_top_assertions.sv
// Checker for the host port and interrupt of the alarm block
`timescale 1ns/1ps
module t1ra_top_assertions #(
	parameter int JA_DEPTH = 32,
	parameter int JA_W = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [JA_W-1:0] jitter_fill,
	input wire logic rx_sync_loss_flag,
	input wire logic rx_mf_pulse,
	input wire logic tx_mf_pulse,
	input wire logic [7:0] host_addr,
	input wire logic [7:0] host_wdata,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [7:0] host_rdata,
	input wire logic int_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence poll_s(a, b);
		host_wr && host_addr == a && host_wdata[b] ##1
		host_rd && host_addr == a;
	endsequence
	sequence mf_s;
		tx_mf_pulse ##2 poll_s(8'h21, 6);
	endsequence
	AST_JITTER: assert property (poll_s(8'h10, 5) |=>
		host_rdata[5] == ($past(jitter_fill, 2) >= JA_DEPTH - 4))
		else $error("jitter flag wrong");
	AST_SPARE: assert property (host_rd && host_addr == 8'h10 |=>
		host_rdata[2:0] == 3'h0) else $error("spare bits wrong");
	AST_SYNC: assert property (poll_s(8'h20, 0) |=>
		host_rdata[0] == $past(rx_sync_loss_flag, 2))
		else $error("sync loss bit wrong");
	AST_HOLD: assert property (!host_rd |=> $stable(host_rdata))
		else $error("read data moved");
	AST_ALARM_INT: assert property ($changed(rx_sync_loss_flag) |=>
		!int_n) else $error("no interrupt on alarm change");
	AST_EVENT_INT: assert property (rx_mf_pulse || tx_mf_pulse |=>
		!int_n) else $error("no interrupt on event");
	AST_INT_HOLD: assert property (!int_n && !host_rd |=> !int_n)
		else $error("interrupt released without read");
	AST_RELEASE: assert property ($rose(int_n) |-> $past(host_rd))
		else $error("interrupt released early");
	AST_MF: assert property (mf_s |=> host_rdata[6])
		else $error("transmit multiframe flag lost");
endmodule
bind t1ra_top t1ra_top_assertions #(.JA_DEPTH(JA_DEPTH), .JA_W(JA_W)) chk_u (
	.clk, .rstn, .jitter_fill, .rx_sync_loss_flag, .rx_mf_pulse,
	.tx_mf_pulse, .host_addr, .host_wdata, .host_wr, .host_rd, .host_rdata,
	.int_n);

// File: t1ra_top_tb_top.sv
// Self-checking testbench for the receive alarm block
`timescale 1ns/1ps
module t1ra_top_tb_top;
	localparam int JA_DEPTH = 32;
	logic clk, rstn, rx_clock_in, rx_positive_in, rx_negative_in;
	logic rx_level_hi, rx_level_lo, line_bit_valid, line_bit;
	logic rx_sync_loss_flag, esf_mode, yellow_mode_select, chan_valid;
	logic chan_bit2, fbit12_valid, fbit12, fdl_word_valid, rx_mf_pulse;
	logic tx_mf_pulse, host_wr, host_rd, int_n, hold_clk, zeros;
	logic [7:0] jitter_fill, host_addr, host_wdata, host_rdata;
	logic [15:0] fdl_word;
	int errors, checks, cycles;
	t1ra_top #(.BLUE_WINDOW(3000), .JA_DEPTH(JA_DEPTH), .JA_W(8)) dut_u (
		.clk, .rstn, .rx_clock_in, .rx_positive_in, .rx_negative_in,
		.rx_level_hi, .rx_level_lo, .line_bit_valid, .line_bit, .jitter_fill,
		.rx_sync_loss_flag, .esf_mode, .yellow_mode_select, .chan_valid,
		.chan_bit2, .fbit12_valid, .fbit12, .fdl_word_valid, .fdl_word,
		.rx_mf_pulse, .tx_mf_pulse, .host_addr, .host_wdata, .host_wr,
		.host_rd, .host_rdata, .int_n);
	t1ra_line_model line_u (.hold_clk, .zeros, .rx_clock_in, .rx_positive_in,
		.rx_negative_in);
	always #2.5 clk = ~clk;
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			give_verdict();
		end
	end
	task automatic chk(input string nm, input logic [7:0] e, g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic ichk(input logic e);
		chk("int_n", {7'h0, e}, {7'h0, int_n});
	endtask
	// Mask write, read back, compare the bits under k
	task automatic pchk(input logic [7:0] a, m, k, e, input string nm);
		@(posedge clk);
		host_addr <= a;
		host_wdata <= m;
		host_wr <= 1'b1;
		@(posedge clk);
		host_wr <= 1'b0;
		host_rd <= 1'b1;
		@(posedge clk);
		host_rd <= 1'b0;
		#1 chk(nm, e, host_rdata & k);
	endtask
	// k: 0 line bit, 1 channel bit 2, 2 framing bit, 3 link word
	task automatic feed(input int k, input logic [15:0] v, input int n);
		repeat (n) begin
			@(posedge clk);
			line_bit_valid <= (k == 0);
			chan_valid <= (k == 1);
			fbit12_valid <= (k == 2);
			fdl_word_valid <= (k == 3);
			{line_bit, chan_bit2, fbit12} <= {3{v[0]}};
			fdl_word <= v;
		end
		@(posedge clk);
		{line_bit_valid, chan_valid, fbit12_valid, fdl_word_valid} <= 4'h0;
	endtask
	task automatic t_int();
		ichk(1'b1);
		@(posedge clk);
		rx_sync_loss_flag <= 1'b1;
		repeat (3) @(posedge clk);
		#1 ichk(1'b0);
		pchk(8'h20, 8'h01, 8'h01, 8'h01, "sync");
		ichk(1'b1);
		@(posedge clk);
		rx_sync_loss_flag <= 1'b0;
		repeat (3) @(posedge clk);
		pchk(8'h20, 8'h00, 8'h01, 8'h01, "held");
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			rx_mf_pulse <= (k == 0);
			tx_mf_pulse <= (k == 1);
			@(posedge clk);
			{rx_mf_pulse, tx_mf_pulse} <= 2'b00;
			#1 ichk(1'b0);
			pchk(8'h21, 8'hc0, 8'hc0, 8'h80 >> k, "mf");
			ichk(1'b1);
		end
	endtask
	task automatic t_info();
		for (int c = 0; c < 4; c++) begin
			@(posedge clk);
			{rx_level_hi, rx_level_lo} <= c[1:0];
			jitter_fill <= 8'(JA_DEPTH - 5 + c % 2);
			repeat (4) @(posedge clk);
			pchk(8'h10, 8'hff, 8'hf8, {c[1:0], c[0], 5'h0}, "info");
		end
	endtask
	task automatic t_clk();
		@(posedge clk);
		hold_clk <= 1'b1;
		repeat (380) @(posedge clk);
		pchk(8'h10, 8'h10, 8'h10, 8'h00, "clk early");
		repeat (420) @(posedge clk);
		pchk(8'h10, 8'h10, 8'h10, 8'h10, "clk lost");
		hold_clk <= 1'b0;
		repeat (40) @(posedge clk);
		pchk(8'h10, 8'h10, 8'h10, 8'h00, "clk back");
	endtask
	task automatic t_framer();
		@(posedge clk);
		zeros <= 1'b1;
		repeat (2880) @(posedge clk);
		pchk(8'h10, 8'h08, 8'h08, 8'h00, "framer early");
		repeat (400) @(posedge clk);
		pchk(8'h10, 8'h08, 8'h08, 8'h08, "framer lost");
		zeros <= 1'b0;
		repeat (400) @(posedge clk);
		pchk(8'h10, 8'h08, 8'h08, 8'h00, "framer back");
	endtask
	task automatic t_line();
		feed(0, 16'h0, 191);
		pchk(8'h20, 8'h02, 8'h02, 8'h00, "red early");
		feed(0, 16'h0, 1);
		@(posedge clk);
		#1 ichk(1'b0);
		pchk(8'h20, 8'h02, 8'h02, 8'h02, "red set");
		feed(0, 16'h1, 13);
		pchk(8'h20, 8'h02, 8'h02, 8'h02, "red 13");
		feed(0, 16'h1, 1);
		pchk(8'h20, 8'h02, 8'h02, 8'h00, "red clear");
	endtask
	task automatic t_yellow();
		feed(1, 16'h0, 254);
		feed(1, 16'h1, 2);
		pchk(8'h20, 8'h04, 8'h04, 8'h04, "d4 set");
		feed(1, 16'h0, 253);
		feed(1, 16'h1, 3);
		pchk(8'h20, 8'h04, 8'h04, 8'h00, "d4 clear");
		yellow_mode_select <= 1'b1;
		feed(2, 16'h1, 2);
		pchk(8'h20, 8'h04, 8'h04, 8'h04, "fbit set");
		feed(2, 16'h0, 2);
		pchk(8'h20, 8'h04, 8'h04, 8'h00, "fbit clear");
		esf_mode <= 1'b1;
		feed(3, 16'h00ff, 16);
		pchk(8'h20, 8'h04, 8'h04, 8'h04, "esf set");
		feed(3, 16'h00ff, 14);
		feed(3, 16'h0f0f, 2);
		pchk(8'h20, 8'h04, 8'h04, 8'h00, "esf clear");
	endtask
	task automatic t_blue();
		// Blue is judged on the framer pins; host qualifies it with sync loss
		@(posedge clk);
		rx_sync_loss_flag <= 1'b1;
		zeros <= 1'b1;
		repeat (7000) @(posedge clk);
		pchk(8'h20, 8'h08, 8'h08, 8'h00, "blue off");
		@(posedge clk);
		zeros <= 1'b0;
		repeat (7000) @(posedge clk);
		pchk(8'h20, 8'h09, 8'h09, 8'h09, "blue on");
	endtask
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		{rx_level_hi, rx_level_lo, line_bit_valid, line_bit, esf_mode} = '0;
		{rx_sync_loss_flag, yellow_mode_select, chan_valid, chan_bit2} = '0;
		{fbit12_valid, fbit12, fdl_word_valid, rx_mf_pulse, tx_mf_pulse} = '0;
		{host_wr, host_rd, hold_clk, zeros} = '0;
		{jitter_fill, host_addr, host_wdata, fdl_word} = '0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		t_int();
		t_info();
		t_clk();
		t_framer();
		t_line();
		t_yellow();
		t_blue();
		give_verdict();
	end
endmodule
